/* rtl/dpg_regs.vh */
// Register map, field positions, reset values and timing for the datapath guard
`ifndef DPG_REGS_VH
`define DPG_REGS_VH

// ----------------------------------------------------------------
// Register offsets (15-bit register address)
// ----------------------------------------------------------------
`define DPG_ADDR_PATTERN_SELECT 15'h0014
`define DPG_ADDR_ALERT_ENABLE 15'h0020
`define DPG_ADDR_ALERT_STATUS_CLEAR 15'h0024
`define DPG_ADDR_ALERT_STATUS_MODE 15'h0028
`define DPG_ADDR_TRANSMIT_GATE_CONFIG 15'h003F
`define DPG_ADDR_PATTERN_CHECK_CTRL_STATUS 15'h014B
`define DPG_ADDR_PATTERN_ERRORS_I 15'h014C
`define DPG_ADDR_PATTERN_ERRORS_Q 15'h014D

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DPG_SEL15_BIT 2
`define DPG_CHK_EN_BIT 0
`define DPG_CHK_RST_BIT 1
`define DPG_PASS_I_BIT 6
`define DPG_PASS_Q_BIT 7
`define DPG_GATE_SW_ZERO_IN 0
`define DPG_GATE_SW_ZERO_OUT 1
`define DPG_GATE_PIN_ZERO_IN 4
`define DPG_GATE_PIN_ZERO_OUT 5
`define DPG_GATE_PIN_RAMP 6
`define DPG_GATE_PIN_NCO_RST 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DPG_RST_PATTERN_SELECT 8'h00
`define DPG_RST_ALERT_ENABLE 2'h0
`define DPG_RST_ALERT_STATUS_MODE 2'h0
`define DPG_RST_TRANSMIT_GATE_CONFIG 8'h00
`define DPG_RST_CHECK_CTRL 2'h0

// ----------------------------------------------------------------
// Full-scale current ramp and timing
// ----------------------------------------------------------------
`define DPG_FSC_MAX 8'hFF
`define DPG_FSC_MIN 8'h1A
`define DPG_CLK_NS 50
`define DPG_RAMP_STEP_NS 200
`define DPG_RAMP_STEP_CYC ((`DPG_RAMP_STEP_NS + `DPG_CLK_NS - 1) / `DPG_CLK_NS)

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define DPG_SPI_FRAME_BITS 24
`define DPG_SPI_HDR_BITS 16

`endif

/* rtl/dpg_spi_slave.v */
// Serial register port slave with synchronised pins
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_spi_slave (
	input wire sys_clk,
	input wire reset_n,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	input wire [7:0] rdata,
	output reg miso_out,
	output reg miso_oe,
	output reg wr_stb,
	output reg [14:0] addr,
	output reg [7:0] wdata
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	wire [2:0] pin_raw;
	reg [2:0] pin_clean;
	reg [2:0] pin_prev;
	assign pin_raw = {spi_sclk, spi_cs_n, spi_mosi};

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			reg s1;
			reg s2;
			reg s3;
			always @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					s1 <= (g == 1) ? 1'b1 : 1'b0;
					s2 <= (g == 1) ? 1'b1 : 1'b0;
					s3 <= (g == 1) ? 1'b1 : 1'b0;
					pin_clean[g] <= (g == 1) ? 1'b1 : 1'b0;
				end else begin
					s1 <= pin_raw[g];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						pin_clean[g] <= s3;
					end
				end
			end
		end
	endgenerate

	wire sclk_rise;
	wire sclk_fall;
	wire cs_act;
	assign sclk_rise = pin_clean[2] & ~pin_prev[2];
	assign sclk_fall = ~pin_clean[2] & pin_prev[2];
	assign cs_act = ~pin_clean[1];

	// ----------------------------------------------------------------
	// Frame shifter
	// ----------------------------------------------------------------
	reg [4:0] bit_cnt;
	reg [22:0] shift_in;
	reg is_read;
	reg load_pend;
	reg [7:0] shift_out;

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_prev <= 3'b010;
			bit_cnt <= 5'd0;
			shift_in <= 23'd0;
			is_read <= 1'b0;
			load_pend <= 1'b0;
			shift_out <= 8'h00;
			miso_out <= 1'b0;
			miso_oe <= 1'b0;
			wr_stb <= 1'b0;
			addr <= 15'h0000;
			wdata <= 8'h00;
		end else begin
			pin_prev <= pin_clean;
			wr_stb <= 1'b0;
			load_pend <= 1'b0;
			if (!cs_act) begin
				bit_cnt <= 5'd0;
				miso_oe <= 1'b0;
			end else begin
				if (sclk_rise && bit_cnt < 5'd24) begin
					bit_cnt <= bit_cnt + 5'd1;
					shift_in <= {shift_in[21:0], pin_clean[0]};
					if (bit_cnt == 5'd15) begin
						is_read <= shift_in[14];
						addr <= {shift_in[13:0], pin_clean[0]};
						load_pend <= shift_in[14];
					end
					if (bit_cnt == 5'd23 && !is_read) begin
						wdata <= {shift_in[6:0], pin_clean[0]};
						wr_stb <= 1'b1;
					end
				end
				if (load_pend) begin
					shift_out <= {rdata[6:0], 1'b0};
					miso_out <= rdata[7];
					miso_oe <= 1'b1;
				end else if (sclk_fall && is_read && bit_cnt > 5'd16) begin
					miso_out <= shift_out[7];
					shift_out <= {shift_out[6:0], 1'b0};
				end
			end
		end
	end

endmodule // dpg_spi_slave

/* rtl/dpg_prbs_check.v */
// Self-synchronising pattern checker for one channel
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_prbs_check (
	input wire sys_clk,
	input wire reset_n,
	input wire chk_en,
	input wire chk_clear,
	input wire sel15,
	input wire sample_valid,
	input wire [15:0] sample,
	output reg pass,
	output reg [7:0] err_count
);

	reg half;
	reg [15:0] first;
	reg [31:0] prev;
	reg have_prev;
	wire [31:0] grp;
	wire [63:0] win;
	wire [31:0] expect_bits;
	wire mismatch;

	assign grp = {sample, first};
	assign win = {grp, prev};

	// ----------------------------------------------------------------
	// Predict each new bit from the earlier ones
	// ----------------------------------------------------------------
	genvar k;
	generate
		for (k = 0; k < 32; k = k + 1) begin : g_pred
			assign expect_bits[k] = sel15 ? (win[32 + k - 15] ^ win[32 + k - 14]) :
				(win[32 + k - 7] ^ win[32 + k - 6]);
		end
	endgenerate
	assign mismatch = |(expect_bits ^ grp);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			half <= 1'b0;
			first <= 16'h0000;
			prev <= 32'h0000_0000;
			have_prev <= 1'b0;
			pass <= 1'b1;
			err_count <= 8'h00;
		end else if (chk_clear || !chk_en) begin
			half <= 1'b0;
			have_prev <= 1'b0;
			if (chk_clear) begin
				pass <= 1'b1;
				err_count <= 8'h00;
			end
		end else if (sample_valid) begin
			if (!half) begin
				first <= sample;
				half <= 1'b1;
			end else begin
				half <= 1'b0;
				prev <= grp;
				have_prev <= 1'b1;
				if (have_prev && mismatch) begin
					pass <= 1'b0;
					if (err_count != 8'hFF) begin
						err_count <= err_count + 8'h01;
					end
				end
			end
		end
	end

endmodule // dpg_prbs_check

/* rtl/dpg_top.v */
// Datapath guard: link blanking, transmit gate, pattern check and alert line
// Functional notes
// - Any link quality flag zeroes samples headed to the DAC decoder.
// - Software can zero the datapath input or the datapath output.
// - Input zeroing decays through filters; in bypass the DAC drops at once.
// - Gate pin effect chosen by gate config register, input or output zeroing.
// - Gate pin can ramp full-scale current between full and minimum.
// - Gate pin can reset the oscillator phase accumulator.
// - Control 0b11 enables and holds checker reset, 0b01 runs it.
// - Pass flags at bits 6 (I) and 7 (Q) read 0 after any error.
// - Separate readable error counts for I and Q channels.
// - Each 32-bit group checked against previous; one error counted per group.
// - I and Q failures are alert events with enable and status registers.
// - Open-drain active-low alert pulled low while any latched source is high.
// - Disabled event keeps its latched source at zero.
// - Enabled event's rising edge sets its latched source.
// - Latched source clears on its reset write or on device reset.
// - Status bit returns raw event or latched source per status mode.
// - Event blocks scale to many events; this block carries two.
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_top (
	input wire sys_clk,
	input wire reset_n,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	output wire spi_miso_out,
	output wire spi_miso_oe,
	output reg alert_n_out,
	output reg alert_n_oe,
	input wire tx_gate_pin,
	input wire [3:0] link_fault,
	input wire bypass_1x,
	input wire sample_valid,
	input wire [15:0] sample_in_i,
	input wire [15:0] sample_in_q,
	output reg dp_in_valid,
	output reg [15:0] dp_in_i,
	output reg [15:0] dp_in_q,
	input wire [15:0] filt_out_i,
	input wire [15:0] filt_out_q,
	output reg [15:0] dac_i,
	output reg [15:0] dac_q,
	output reg [7:0] fsc_level,
	output reg nco_phase_reset
);

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	wire wr_stb;
	wire [14:0] reg_addr;
	wire [7:0] reg_wdata;
	reg [7:0] reg_rdata;

	dpg_spi_slave u_spi (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.rdata(reg_rdata),
		.miso_out(spi_miso_out),
		.miso_oe(spi_miso_oe),
		.wr_stb(wr_stb),
		.addr(reg_addr),
		.wdata(reg_wdata)
	);

	reg [7:0] pattern_select;
	reg [1:0] alert_enable;
	reg [1:0] alert_status_mode;
	reg [7:0] transmit_gate_config;
	reg [1:0] check_ctrl;
	reg [1:0] irq_src;
	reg [1:0] irq_clr;

	wire pass_i;
	wire pass_q;
	wire [7:0] err_i;
	wire [7:0] err_q;
	wire [1:0] fail_event;
	wire [1:0] event_status;

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pattern_select <= `DPG_RST_PATTERN_SELECT;
			alert_enable <= `DPG_RST_ALERT_ENABLE;
			alert_status_mode <= `DPG_RST_ALERT_STATUS_MODE;
			transmit_gate_config <= `DPG_RST_TRANSMIT_GATE_CONFIG;
			check_ctrl <= `DPG_RST_CHECK_CTRL;
			irq_clr <= 2'b00;
		end else begin
			irq_clr <= 2'b00;
			if (wr_stb) begin
				case (reg_addr)
					`DPG_ADDR_PATTERN_SELECT: begin
						pattern_select <= reg_wdata;
					end
					`DPG_ADDR_ALERT_ENABLE: begin
						alert_enable <= reg_wdata[1:0];
					end
					`DPG_ADDR_ALERT_STATUS_CLEAR: begin
						irq_clr <= reg_wdata[1:0];
					end
					`DPG_ADDR_ALERT_STATUS_MODE: begin
						alert_status_mode <= reg_wdata[1:0];
					end
					`DPG_ADDR_TRANSMIT_GATE_CONFIG: begin
						transmit_gate_config <= reg_wdata;
					end
					`DPG_ADDR_PATTERN_CHECK_CTRL_STATUS: begin
						check_ctrl <= reg_wdata[1:0];
					end
					default: begin
						check_ctrl <= check_ctrl;
					end
				endcase
			end
		end
	end

	// Readback; unmapped addresses read zero
	always @* begin
		reg_rdata = 8'h00;
		case (reg_addr)
			`DPG_ADDR_PATTERN_SELECT: begin
				reg_rdata = pattern_select;
			end
			`DPG_ADDR_ALERT_ENABLE: begin
				reg_rdata = {6'b000000, alert_enable};
			end
			`DPG_ADDR_ALERT_STATUS_CLEAR: begin
				reg_rdata = {6'b000000, event_status};
			end
			`DPG_ADDR_ALERT_STATUS_MODE: begin
				reg_rdata = {6'b000000, alert_status_mode};
			end
			`DPG_ADDR_TRANSMIT_GATE_CONFIG: begin
				reg_rdata = transmit_gate_config;
			end
			`DPG_ADDR_PATTERN_CHECK_CTRL_STATUS: begin
				reg_rdata = {pass_q, pass_i, 4'b0000, check_ctrl};
			end
			`DPG_ADDR_PATTERN_ERRORS_I: begin
				reg_rdata = err_i;
			end
			`DPG_ADDR_PATTERN_ERRORS_Q: begin
				reg_rdata = err_q;
			end
			default: begin
				reg_rdata = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Pattern checkers
	// ----------------------------------------------------------------
	wire chk_en;
	wire chk_clear;
	wire sel15;
	assign chk_en = check_ctrl[`DPG_CHK_EN_BIT];
	assign chk_clear = check_ctrl[`DPG_CHK_RST_BIT];
	assign sel15 = pattern_select[`DPG_SEL15_BIT];

	dpg_prbs_check u_chk_i (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.chk_en(chk_en),
		.chk_clear(chk_clear),
		.sel15(sel15),
		.sample_valid(sample_valid),
		.sample(sample_in_i),
		.pass(pass_i),
		.err_count(err_i)
	);

	dpg_prbs_check u_chk_q (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.chk_en(chk_en),
		.chk_clear(chk_clear),
		.sel15(sel15),
		.sample_valid(sample_valid),
		.sample(sample_in_q),
		.pass(pass_q),
		.err_count(err_q)
	);

	// ----------------------------------------------------------------
	// Alert events, two of a scalable event set
	// ----------------------------------------------------------------
	reg [1:0] event_d;
	assign fail_event = {~pass_q, ~pass_i};

	genvar e;
	generate
		for (e = 0; e < 2; e = e + 1) begin : g_irq
			always @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					irq_src[e] <= 1'b0;
					event_d[e] <= 1'b0;
				end else begin
					event_d[e] <= fail_event[e];
					if (!alert_enable[e]) begin
						irq_src[e] <= 1'b0;
					end else if (fail_event[e] && !event_d[e]) begin
						irq_src[e] <= 1'b1;
					end else if (irq_clr[e]) begin
						irq_src[e] <= 1'b0;
					end
				end
			end
			assign event_status[e] = alert_status_mode[e] ? irq_src[e] : fail_event[e];
		end
	endgenerate

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			alert_n_out <= 1'b0;
			alert_n_oe <= 1'b0;
		end else begin
			alert_n_out <= 1'b0;
			alert_n_oe <= |irq_src;
		end
	end

	// ----------------------------------------------------------------
	// Gate pin synchroniser
	// ----------------------------------------------------------------
	reg pin_s1;
	reg pin_s2;
	reg pin_s3;
	reg pin_on;
	reg pin_on_d;

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
			pin_on <= 1'b0;
			pin_on_d <= 1'b0;
		end else begin
			pin_s1 <= tx_gate_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3) begin
				pin_on <= pin_s3;
			end
			pin_on_d <= pin_on;
		end
	end

	// ----------------------------------------------------------------
	// Datapath zeroing
	// ----------------------------------------------------------------
	wire zero_in;
	wire zero_out;
	wire link_bad;
	wire [15:0] src_i;
	wire [15:0] src_q;
	wire blank_dac;

	assign zero_in = transmit_gate_config[`DPG_GATE_SW_ZERO_IN] |
		(transmit_gate_config[`DPG_GATE_PIN_ZERO_IN] & ~pin_on);
	assign zero_out = transmit_gate_config[`DPG_GATE_SW_ZERO_OUT] |
		(transmit_gate_config[`DPG_GATE_PIN_ZERO_OUT] & ~pin_on);
	assign link_bad = |link_fault;
	assign src_i = bypass_1x ? sample_in_i : filt_out_i;
	assign src_q = bypass_1x ? sample_in_q : filt_out_q;
	assign blank_dac = link_bad | zero_out | (bypass_1x & zero_in);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dp_in_valid <= 1'b0;
			dp_in_i <= 16'h0000;
			dp_in_q <= 16'h0000;
			dac_i <= 16'h0000;
			dac_q <= 16'h0000;
		end else begin
			dp_in_valid <= sample_valid;
			dp_in_i <= zero_in ? 16'h0000 : sample_in_i;
			dp_in_q <= zero_in ? 16'h0000 : sample_in_q;
			dac_i <= blank_dac ? 16'h0000 : src_i;
			dac_q <= blank_dac ? 16'h0000 : src_q;
		end
	end

	// ----------------------------------------------------------------
	// Full-scale ramp and oscillator reset
	// ----------------------------------------------------------------
	reg [3:0] ramp_cnt;
	wire ramp_down;
	wire ramp_tick;
	wire [31:0] ramp_last;
	assign ramp_down = transmit_gate_config[`DPG_GATE_PIN_RAMP] & ~pin_on;
	assign ramp_last = `DPG_RAMP_STEP_CYC - 1;
	assign ramp_tick = (ramp_cnt == ramp_last[3:0]);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ramp_cnt <= 4'h0;
			fsc_level <= `DPG_FSC_MAX;
			nco_phase_reset <= 1'b0;
		end else begin
			ramp_cnt <= ramp_tick ? 4'h0 : ramp_cnt + 4'h1;
			if (ramp_tick) begin
				if (ramp_down && fsc_level > `DPG_FSC_MIN) begin
					fsc_level <= fsc_level - 8'h01;
				end else if (!ramp_down && fsc_level < `DPG_FSC_MAX) begin
					fsc_level <= fsc_level + 8'h01;
				end
			end
			nco_phase_reset <= transmit_gate_config[`DPG_GATE_PIN_NCO_RST] &
				pin_on & ~pin_on_d;
		end
	end

endmodule // dpg_top

/* tb/dpg_top_asserts.sv */
// Bound property checker for the datapath guard top
`timescale 1ns/1ps
module dpg_top_asserts (
	input wire sys_clk,
	input wire reset_n,
	input wire spi_cs_n,
	input wire spi_miso_oe,
	input wire alert_n_out,
	input wire alert_n_oe,
	input wire sample_valid,
	input wire [3:0] link_fault,
	input wire bypass_1x,
	input wire [15:0] sample_in_i,
	input wire [15:0] filt_out_i,
	input wire dp_in_valid,
	input wire [15:0] dp_in_i,
	input wire [15:0] dac_i,
	input wire [15:0] dac_q,
	input wire [7:0] fsc_level,
	input wire nco_phase_reset
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Ramp step and the quiet spell after it
	sequence s_step;
		fsc_level < $past(fsc_level);
	endsequence
	sequence s_quiet;
		(fsc_level >= $past(fsc_level))[*3];
	endsequence
	a_fault_blanks_dac: assert property (|link_fault |=> !(|dac_i) && !(|dac_q))
		else $error("dac not blanked after link fault");
	a_dac_source: assert property (dac_i != 16'h0000 |->
		dac_i == ($past(bypass_1x) ? $past(sample_in_i) : $past(filt_out_i)))
		else $error("dac value not from selected source");
	a_dp_in_source: assert property (dp_in_valid && dp_in_i != 16'h0000 |->
		dp_in_i == $past(sample_in_i))
		else $error("datapath input not from sample");
	a_ramp_single_step: assert property (s_step |-> fsc_level == $past(fsc_level) - 8'h01)
		else $error("current ramp skipped a code");
	a_ramp_step_gap: assert property (s_step |=> s_quiet)
		else $error("current ramp stepped too fast");
	a_nco_one_pulse: assert property (nco_phase_reset |=> !nco_phase_reset)
		else $error("phase reset pulse too long");
	a_alert_pulls_low: assert property (!alert_n_out)
		else $error("alert pin drives high");
	a_alert_needs_fail: assert property ($rose(alert_n_oe) |-> $past(sample_valid, 3))
		else $error("alert raised without a checked sample");
	a_alert_drop_write: assert property ($fell(alert_n_oe) |-> !$past(spi_cs_n, 2))
		else $error("alert released outside a register write");
	a_miso_let_go: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
		else $error("miso driven while deselected");
endmodule // dpg_top_asserts

bind dpg_top dpg_top_asserts dpg_top_asserts_i (
	.sys_clk(sys_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
	.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe), .sample_valid(sample_valid),
	.link_fault(link_fault), .bypass_1x(bypass_1x),
	.sample_in_i(sample_in_i), .filt_out_i(filt_out_i), .dp_in_valid(dp_in_valid),
	.dp_in_i(dp_in_i), .dac_i(dac_i), .dac_q(dac_q), .fsc_level(fsc_level),
	.nco_phase_reset(nco_phase_reset)
);

/* tb/dpg_host_model.sv */
// Host-side serial register master for the datapath guard
`timescale 1ns/1ps
module dpg_host_model (
	input wire sys_clk,
	output reg spi_sclk,
	output reg spi_cs_n,
	output reg spi_mosi,
	input wire spi_miso_out,
	input wire spi_miso_oe
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// One 24-bit mode 0 frame, MSB first, six clocks per phase
	task xfer(input rw, input [14:0] a, input [7:0] d, output [7:0] q);
		reg [23:0] f;
		integer k;
		begin
			f = {rw, a, d};
			q = 8'h00;
			@(posedge sys_clk);
			spi_cs_n <= 1'b0;
			for (k = 23; k >= 0; k = k - 1) begin
				spi_mosi <= f[k];
				repeat (6) @(posedge sys_clk);
				spi_sclk <= 1'b1;
				if (k < 8) q[k] = spi_miso_oe ? spi_miso_out : 1'bx;
				repeat (6) @(posedge sys_clk);
				spi_sclk <= 1'b0;
			end
			repeat (6) @(posedge sys_clk);
			spi_cs_n <= 1'b1;
			spi_mosi <= ~spi_mosi;
			repeat (8) @(posedge sys_clk);
		end
	endtask
endmodule // dpg_host_model

/* tb/dpg_top_tb.sv */
// Self-checking bench for the datapath guard top
`timescale 1ns/1ps
module dpg_top_tb;
	reg sys_clk = 1'b0;
	reg reset_n = 1'b0;
	reg tx_gate_pin = 1'b1;
	reg bypass_1x = 1'b0;
	reg sample_valid = 1'b0;
	reg [3:0] link_fault = 4'h0;
	reg [15:0] sample_in_i = 16'h0000;
	reg [15:0] sample_in_q = 16'h0000;
	reg [15:0] filt_out_i = 16'h0000;
	reg [15:0] filt_out_q = 16'h0000;
	wire spi_sclk, spi_cs_n, spi_mosi, spi_miso_out, spi_miso_oe;
	wire alert_n_out, alert_n_oe, dp_in_valid, nco_phase_reset;
	wire [15:0] dp_in_i, dp_in_q, dac_i, dac_q;
	wire [7:0] fsc_level;
	wire alert_n = alert_n_oe ? alert_n_out : 1'b1;
	integer num_errors = 0;
	integer samples_checked = 0;
	integer n, k, m;
	reg [7:0] rd;
	always #25 sys_clk = ~sys_clk;
	dpg_top dpg_top_i (
		.sys_clk(sys_clk), .reset_n(reset_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe),
		.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe), .tx_gate_pin(tx_gate_pin),
		.link_fault(link_fault), .bypass_1x(bypass_1x), .sample_valid(sample_valid),
		.sample_in_i(sample_in_i), .sample_in_q(sample_in_q), .dp_in_valid(dp_in_valid),
		.dp_in_i(dp_in_i), .dp_in_q(dp_in_q), .filt_out_i(filt_out_i),
		.filt_out_q(filt_out_q), .dac_i(dac_i), .dac_q(dac_q), .fsc_level(fsc_level),
		.nco_phase_reset(nco_phase_reset)
	);
	dpg_host_model dpg_host_model_i (
		.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe)
	);
	task chk(input [95:0] nm, input [15:0] e, input [15:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task rd_chk(input [95:0] nm, input [14:0] a, input [7:0] e);
		begin
			dpg_host_model_i.xfer(1'b1, a, 8'h00, rd);
			chk(nm, {8'h00, e}, {8'h00, rd});
		end
	endtask
	task wr(input [14:0] a, input [7:0] d);
		dpg_host_model_i.xfer(1'b0, a, d, rd);
	endtask
	task cyc(input integer c);
		repeat (c) @(posedge sys_clk);
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", samples_checked, num_errors);
			if (num_errors == 0 && samples_checked > 0) begin
				$display("verification passed");
			end else begin
				$display("verification failed");
			end
			$finish;
		end
	endtask
	task wait_fsc(input [7:0] v);
		begin
			n = 0;
			while (fsc_level !== v && n < 1200) begin
				@(posedge sys_clk);
				n = n + 1;
			end
		end
	endtask
	// Random traffic with the zeroing model
	task dp_run(input [7:0] cfg, input pin);
		reg [15:0] si, fo;
		reg [3:0] lf;
		reg byp, sv, zi, zo, bl;
		begin
			wr(15'h003F, cfg);
			tx_gate_pin <= pin;
			cyc(10);
			zi = cfg[0] | (cfg[4] & ~pin);
			zo = cfg[1] | (cfg[5] & ~pin);
			repeat (30) begin
				{si, fo} = $urandom;
				n = $urandom;
				lf = (n[5:4] == 2'b00) ? n[3:0] : 4'h0;
				byp = n[6];
				sv = n[7];
				sample_in_i <= si;
				sample_in_q <= ~si;
				filt_out_i <= fo;
				filt_out_q <= ~fo;
				link_fault <= lf;
				bypass_1x <= byp;
				sample_valid <= sv;
				@(posedge sys_clk);
				#1;
				bl = (|lf) | zo | (byp & zi);
				chk("dac_i", bl ? 16'h0000 : (byp ? si : fo), dac_i);
				chk("dac_q", bl ? 16'h0000 : ~(byp ? si : fo), dac_q);
				chk("dp_valid", {15'h0000, sv}, {15'h0000, dp_in_valid});
				if (sv) chk("dp_in_i", zi ? 16'h0000 : si, dp_in_i);
				if (sv) chk("dp_in_q", zi ? 16'h0000 : ~si, dp_in_q);
				@(posedge sys_clk);
			end
			sample_valid <= 1'b0;
			link_fault <= 4'h0;
		end
	endtask
	// Pattern run with self-synchronising error model
	task prbs_run(input sel, input qbad);
		reg [14:0] h, r;
		reg [15:0] wi, wq;
		reg b, x, ge;
		integer g, s, j, ne;
		begin
			wr(15'h0014, {5'h00, sel, 2'h0});
			wr(15'h014B, 8'h03);
			rd_chk("chk_hold", 15'h014B, 8'hC3);
			rd_chk("err_i_clr", 15'h014C, 8'h00);
			rd_chk("err_q_clr", 15'h014D, 8'h00);
			wr(15'h014B, 8'h01);
			h = 15'h7FFF;
			r = h;
			ne = 0;
			for (g = 0; g < 12; g = g + 1) begin
				ge = 1'b0;
				for (s = 0; s < 2; s = s + 1) begin
					for (j = 0; j < 16; j = j + 1) begin
						b = sel ? h[14] ^ h[13] : h[6] ^ h[5];
						h = {h[13:0], b};
						x = b ^ ((g == 5 && s == 1 && j == 15) || (g == 8 && s == 1 && j > 5));
						if (x !== (sel ? r[14] ^ r[13] : r[6] ^ r[5])) ge = 1'b1;
						r = {r[13:0], x};
						wi[j] = qbad ? b : x;
						wq[j] = qbad ? x : b;
					end
					sample_in_i <= wi;
					sample_in_q <= wq;
					sample_valid <= 1'b1;
					@(posedge sys_clk);
				end
				if (g > 0 && ge) ne = ne + 1;
			end
			sample_valid <= 1'b0;
			cyc(10);
			rd_chk("pass_flags", 15'h014B, qbad ? 8'h41 : 8'h81);
			rd_chk("err_i", 15'h014C, qbad ? 8'h00 : ne[7:0]);
			rd_chk("err_q", 15'h014D, qbad ? ne[7:0] : 8'h00);
		end
	endtask
	initial begin
		n = $urandom(32'ha77a_9df7);
		cyc(10);
		reset_n <= 1'b1;
		cyc(2);
		rd_chk("sel", 15'h0014, 8'h00);
		rd_chk("irq_en", 15'h0020, 8'h00);
		rd_chk("irq_stat", 15'h0024, 8'h00);
		rd_chk("gate_cfg", 15'h003F, 8'h00);
		rd_chk("chk_stat", 15'h014B, 8'hC0);
		rd_chk("err_i", 15'h014C, 8'h00);
		rd_chk("err_q", 15'h014D, 8'h00);
		rd_chk("unmapped", 15'h0100, 8'h00);
		chk("fsc", 16'h00FF, {8'h00, fsc_level});
		dp_run(8'h00, 1'b1);
		dp_run(8'h01, 1'b1);
		dp_run(8'h02, 1'b1);
		dp_run(8'h10, 1'b0);
		dp_run(8'h20, 1'b0);
		tx_gate_pin <= 1'b1;
		cyc(10);
		wr(15'h003F, 8'h40);
		tx_gate_pin <= 1'b0;
		wait_fsc(8'h1A);
		chk("ramp_time", 16'h0001, {15'h0000, n >= 912 && n < 940});
		cyc(20);
		chk("fsc_min", 16'h001A, {8'h00, fsc_level});
		tx_gate_pin <= 1'b1;
		wait_fsc(8'hFF);
		chk("fsc_max", 16'h00FF, {8'h00, fsc_level});
		for (k = 0; k < 2; k = k + 1) begin
			wr(15'h003F, k ? 8'h00 : 8'h80);
			tx_gate_pin <= 1'b0;
			cyc(10);
			tx_gate_pin <= 1'b1;
			m = 0;
			repeat (20) begin
				@(posedge sys_clk);
				m = m + nco_phase_reset;
			end
			chk("nco_pulses", k ? 16'h0000 : 16'h0001, m[15:0]);
		end
		wr(15'h0020, 8'h03);
		prbs_run(1'b0, 1'b0);
		chk("alert_n", 16'h0000, {15'h0000, alert_n});
		rd_chk("irq_raw", 15'h0024, 8'h01);
		wr(15'h0028, 8'h03);
		rd_chk("irq_latch", 15'h0024, 8'h01);
		wr(15'h0020, 8'h00);
		rd_chk("irq_off", 15'h0024, 8'h00);
		chk("alert_n", 16'h0001, {15'h0000, alert_n});
		wr(15'h0020, 8'h03);
		rd_chk("irq_level", 15'h0024, 8'h00);
		prbs_run(1'b1, 1'b1);
		rd_chk("irq_q", 15'h0024, 8'h02);
		chk("alert_n", 16'h0000, {15'h0000, alert_n});
		wr(15'h0024, 8'h02);
		rd_chk("irq_clr", 15'h0024, 8'h00);
		chk("alert_n", 16'h0001, {15'h0000, alert_n});
		print_verdict;
	end
	initial begin
		#2500000;
		num_errors = num_errors + 1;
		print_verdict;
	end
endmodule // dpg_top_tb
